// *** tape_reader_defines.svh ***
`ifndef TAPE_READER_DEFINES_SVH
`define TAPE_READER_DEFINES_SVH

// Register byte addresses.
`define REG_CONFIG        32'h0000_0000
`define REG_STATUS        32'h0000_0004

// Configuration word layout.
`define CFG_SYNC          0
`define CFG_INVERT        1
`define CFG_LEVELS_LO     2
`define CFG_INTERVAL_LO   8
`define CFG_HEADER_LO     16
`define CONFIG_RESET      32'h000a_0b0c

// Status word layout.
`define ST_VER_ALARM      0
`define ST_FEED_ALARM     1
`define ST_DELETE         2
`define ST_STOP           3
`define ST_ON_LINE        4
`define ST_COUNT_LO       8

// Answers on the register bus.
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// Pin vector layout: switch make contacts, break contacts, then the rest.
`define NUM_PINS          13
`define NUM_SW            5
`define SW_STOP           0
`define SW_STEP_READ      1
`define SW_STEP           2
`define SW_VER_RESET      3
`define SW_FEED_RESET     4
`define PIN_BREAK_LO      5
`define PIN_VER_ERR       10
`define PIN_FEED_ERR      11
`define PIN_BIT_CLK       12

// Bit counter figures.
`define LOAD_START_STOP   4'h0
`define LOAD_SYNC         4'h1
`define DATA_COUNT_MAX    4'h8
`define MIN_LEVELS        4'h5
`define MIN_PULSE_SS      5'h06
`define MIN_PULSE_SYNC    5'h05
`define MAX_PULSE         5'h10

`endif

// *** tape_reader_pkg.sv ***
`include "tape_reader_defines.svh"

package tape_reader_pkg;

  typedef struct packed {
    logic [3:0] count;
    logic [7:0] storage;
    logic       serial;
    logic       char_step;
  } conv_state_t;

  typedef struct packed {
    logic [`NUM_PINS-1:0] s1;
    logic [`NUM_PINS-1:0] s2;
    logic [`NUM_PINS-1:0] s3;
    logic [`NUM_PINS-1:0] pin;
    logic [`NUM_SW-1:0]   sw;
    logic                 hdr_prev;
    logic                 delete_latch;
    logic                 step_read_latch;
    logic                 stepped;
    logic                 ver_alarm;
    logic                 feed_alarm;
    logic                 reader_stop;
    logic                 header_step;
    logic                 reader_step;
    logic                 step_read_pulse;
    logic                 restart_guard;
    logic                 alarm_active;
    logic                 on_line_lamp;
    logic                 cfg_sync;
    logic                 cfg_invert;
    logic [1:0]           cfg_levels;
    logic [4:0]           cfg_interval;
    logic [4:0]           cfg_header;
    logic                 aw_full;
    logic [31:0]          aw_addr;
    logic                 w_full;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } main_state_t;

endpackage

// *** serializer_if.sv ***
`timescale 1ns/100ps

interface serializer_if;
  logic       bit_fall;
  logic [7:0] char_data;
  logic       sync_mode;
  logic       invert;
  logic [1:0] levels;
  logic [4:0] interval;
  logic [4:0] header_n;
  logic       header_seq;
  logic       serial_out;
  logic       char_step;
  logic [7:0] par_out;
  logic [3:0] count;

  modport ctrl (
    output bit_fall, char_data, sync_mode, invert, levels, interval,
           header_n, header_seq,
    input  serial_out, char_step, par_out, count
  );
  modport conv (
    input  bit_fall, char_data, sync_mode, invert, levels, interval,
           header_n, header_seq,
    output serial_out, char_step, par_out, count
  );
endinterface

// *** tape_serializer.sv ***
`timescale 1ns/100ps
`include "tape_reader_defines.svh"

module tape_serializer #(
  parameter int LEVELS = 8
) (
  // Clock and reset
  input wire logic    aclk,
  input wire logic    aresetn,
  // Control side
  serializer_if.conv  cv
);

  if (LEVELS < 5 || LEVELS > 8) begin : g_bad_levels
    $error("tape_serializer: LEVELS must be 5 to 8");
  end

  tape_reader_pkg::conv_state_t st;
  tape_reader_pkg::conv_state_t next_st;

  // Pulse number on which the counter reloads, held inside the legal range.
  function automatic logic [4:0] clamp_pulse(input logic [4:0] n,
                                             input logic       sync);
    logic [4:0] lo;
    lo = sync ? `MIN_PULSE_SYNC : `MIN_PULSE_SS;
    if (n < lo)
      clamp_pulse = lo;
    else if (n > `MAX_PULSE)
      clamp_pulse = `MAX_PULSE;
    else
      clamp_pulse = n;
  endfunction

  // Serial level for a count; a mark is 1.
  function automatic logic bit_select(input logic [3:0] cnt,
                                      input logic [7:0] store,
                                      input logic       sync,
                                      input logic [1:0] lv,
                                      input logic       inv);
    logic [3:0] idx;
    logic [3:0] used;
    idx  = cnt - 4'h1;
    used = `MIN_LEVELS + {2'h0, lv};
    if (used > 4'(LEVELS))
      used = 4'(LEVELS);
    if (cnt == 4'h0)
      bit_select = sync;
    else if (cnt > `DATA_COUNT_MAX)
      bit_select = 1'b1;
    else if (idx >= used)
      bit_select = 1'b1;
    else
      bit_select = store[idx[2:0]] ^ inv;
  endfunction

  always_comb begin
    logic [4:0] target;
    logic [3:0] probe;
    target = 5'h00;
    probe  = 4'h0;
    next_st = st;
    next_st.char_step = 1'b0;
    target = cv.header_seq ? clamp_pulse(cv.header_n, cv.sync_mode)
                           : clamp_pulse(cv.interval, cv.sync_mode);
    // Start-stop reloads one count earlier than synchronous for a pulse.
    probe = cv.sync_mode ? st.count : st.count + 4'h1;
    if (cv.bit_fall) begin
      if (probe == target[3:0]) begin
        next_st.count = cv.sync_mode ? `LOAD_SYNC
                                     : `LOAD_START_STOP;
        next_st.storage   = cv.char_data;
        next_st.char_step = 1'b1;
      end else begin
        next_st.count = st.count + 4'h1;
      end
      next_st.serial = bit_select(next_st.count, next_st.storage,
                                  cv.sync_mode, cv.levels, cv.invert);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st.count     <= `LOAD_START_STOP;
      st.storage   <= 8'h00;
      st.serial    <= 1'b1;
      st.char_step <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign cv.serial_out = st.serial;
  assign cv.char_step  = st.char_step;
  assign cv.par_out    = st.storage;
  assign cv.count      = st.count;

endmodule

// *** tape_reader_control_serializer.sv ***
// Behaviour
// - Falling header-complete clears the header-delete latch while on-line.
// - Cleared latch drops delete mode; steps go to the reader.
// - Stop switch with on-line raises reader stop, blocking sequence steps.
// - Operator switches pass a set-reset latch to remove bounce.
// - Step-read rise during reader stop latches and emits one step pulse.
// - Manual steps blocked when stop normal and on-line; else passed.
// - Passed manual steps reach the step driver with sequence steps.
// - Stop release after manual stepping sends restart guard to verifier.
// - Verifier and tape-feed alarm latches set by errors while on-line.
// - A set alarm lights its lamp and drives combined alarm.
// - An alarm reset switch clears its latch and lamp.
// - On-line lamp follows the on-line signal.
// - Converter serialises a five to eight level parallel character.
// - Bit rate comes only from the supplied bit clock.
// - One reader step pulse per transmitted character.
// - Stored character also offered on a parallel output.
// - Four-stage counter reloads at the count chosen by interval select, or by the header count during a message header sequence.
// - Reload clears upper stages; lowest stage set only in synchronous.
// - Counter advances on falling edges of the bit clock.
// - Counter value selects which stored level drives the serial line.
// - Reload value is 0000 start-stop and 0001 synchronous.
// - Counts above eight send mark until the next reload.
// - Reload pulse selectable, sixth or fifth through sixteenth.
`timescale 1ns/100ps
`include "tape_reader_defines.svh"

module tape_reader_control_serializer (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Register bus write address
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // Register bus write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // Register bus write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Register bus read address
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // Register bus read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Sequence control logic
  input  wire logic        on_line,
  input  wire logic        header_complete,
  input  wire logic        header_delete_set,
  input  wire logic        message_header_sequence,
  input  wire logic        seq_step,
  output logic             delete_mode,
  output logic             reader_stop,
  output logic             header_step,
  // Operator switch contacts, error pins and bit clock
  input  wire logic [4:0]  sw_make,
  input  wire logic [4:0]  sw_break,
  input  wire logic        verifier_err,
  input  wire logic        feed_err,
  input  wire logic        bit_clk,
  // Reader driver and verifier
  input  wire logic [7:0]  char_data,
  output logic             reader_step,
  output logic             step_read_pulse,
  output logic             restart_guard,
  output logic             alarm_active,
  // Lamps
  output logic             verifier_lamp,
  output logic             feed_lamp,
  output logic             on_line_lamp,
  // Converter outputs
  output logic             serial_out,
  output logic             char_step,
  output logic [7:0]       par_out
);

  tape_reader_pkg::main_state_t st;
  tape_reader_pkg::main_state_t next_st;

  serializer_if             cv ();

  logic [`NUM_PINS-1:0] pins;
  logic [`NUM_PINS-1:0] agree;
  logic [`NUM_PINS-1:0] pin_now;
  logic                 bit_fall;
  logic [3:0]           conv_count;

  // Bus protection bits carry no meaning for this block.
  logic                 prot_unused;
  assign prot_unused = ^{awprot, arprot};

  assign pins = {bit_clk, feed_err, verifier_err, sw_break, sw_make};

  // A filtered pin only moves once the second and third stages agree, so a
  // level caught mid-change never reaches the latches.
  assign agree    = ~(st.s2 ^ st.s3);
  assign pin_now  = (st.pin & ~agree) | (st.s3 & agree);
  assign bit_fall = st.pin[`PIN_BIT_CLK] & ~pin_now[`PIN_BIT_CLK];

  // Configuration image as software sees it.
  function automatic logic [31:0] cfg_image(
      input tape_reader_pkg::main_state_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[`CFG_SYNC]                          = s.cfg_sync;
    v[`CFG_INVERT]                        = s.cfg_invert;
    v[`CFG_LEVELS_LO+1:`CFG_LEVELS_LO]     = s.cfg_levels;
    v[`CFG_INTERVAL_LO+4:`CFG_INTERVAL_LO] = s.cfg_interval;
    v[`CFG_HEADER_LO+4:`CFG_HEADER_LO]     = s.cfg_header;
    cfg_image = v;
  endfunction

  // Status image as software sees it.
  function automatic logic [31:0] status_image(
      input tape_reader_pkg::main_state_t s,
      input logic [3:0] cnt,
      input logic       online);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[`ST_VER_ALARM]                  = s.ver_alarm;
    v[`ST_FEED_ALARM]                 = s.feed_alarm;
    v[`ST_DELETE]                     = s.delete_latch;
    v[`ST_STOP]                       = s.reader_stop;
    v[`ST_ON_LINE]                    = online;
    v[`ST_COUNT_LO+3:`ST_COUNT_LO]     = cnt;
    status_image = v;
  endfunction

  always_comb begin
    logic [`NUM_SW-1:0] mk;
    logic [`NUM_SW-1:0] bk;
    logic [`NUM_SW-1:0] sw_rise;
    logic [`NUM_SW-1:0] sw_fall;
    logic               hdr_fall;
    logic               stop_on;
    logic               manual_ok;
    logic               manual;
    logic               seq_reader;
    logic [31:0]        cfg;
    logic [31:0]        merged;
    mk         = '0;
    bk         = '0;
    sw_rise    = '0;
    sw_fall    = '0;
    hdr_fall   = 1'b0;
    stop_on    = 1'b0;
    manual_ok  = 1'b0;
    manual     = 1'b0;
    seq_reader = 1'b0;
    cfg        = 32'h0000_0000;
    merged     = 32'h0000_0000;
    next_st    = st;

    // Three-stage synchroniser and filtered levels.
    next_st.s1  = pins;
    next_st.s2  = st.s1;
    next_st.s3  = st.s2;
    next_st.pin = pin_now;

    // Each switch has a make and a break contact; bounce on one contact
    // cannot move the latch while the other still holds it.
    mk = pin_now[`NUM_SW-1:0];
    bk = pin_now[`PIN_BREAK_LO+`NUM_SW-1:`PIN_BREAK_LO];
    next_st.sw = (st.sw | (mk & ~bk)) & ~(bk & ~mk);
    sw_rise    = next_st.sw & ~st.sw;
    sw_fall    = st.sw & ~next_st.sw;

    // Header-delete latch; a new set outranks a clear in the same cycle.
    next_st.hdr_prev = header_complete;
    hdr_fall = st.hdr_prev & ~header_complete;
    if (hdr_fall && on_line)
      next_st.delete_latch = 1'b0;
    if (header_delete_set)
      next_st.delete_latch = 1'b1;

    // Reader stop blocks both step destinations.
    stop_on = next_st.sw[`SW_STOP];
    next_st.reader_stop = stop_on & on_line;
    next_st.header_step = seq_step & st.delete_latch
                          & ~next_st.reader_stop;
    seq_reader = seq_step & ~st.delete_latch
                 & ~next_st.reader_stop;

    // Step-read: one pulse per press; the latch waits for the release.
    next_st.step_read_pulse = 1'b0;
    if (sw_rise[`SW_STEP_READ] && next_st.reader_stop
        && !st.step_read_latch) begin
      next_st.step_read_latch = 1'b1;
      next_st.step_read_pulse = 1'b1;
    end else if (sw_fall[`SW_STEP_READ] || !next_st.reader_stop) begin
      // Leaving reader stop hands stepping back to the sequence pulses.
      next_st.step_read_latch = 1'b0;
    end

    // Manual step is held while the reader runs on incoming pulses.
    manual_ok = ~(~stop_on & on_line);
    manual    = sw_rise[`SW_STEP] & manual_ok;
    next_st.reader_step = seq_reader | manual
                          | next_st.step_read_pulse;

    // Restart guard only after a manual step while stopped.
    next_st.restart_guard = 1'b0;
    if (manual && stop_on)
      next_st.stepped = 1'b1;
    if (sw_fall[`SW_STOP]) begin
      next_st.restart_guard = on_line & ~next_st.sw[`SW_STEP]
                              & st.stepped;
      next_st.stepped = 1'b0;
    end

    // Alarms: an error in the clearing cycle still sets the latch.
    if (sw_rise[`SW_VER_RESET])
      next_st.ver_alarm = 1'b0;
    if (sw_rise[`SW_FEED_RESET])
      next_st.feed_alarm = 1'b0;
    if (pin_now[`PIN_VER_ERR] && on_line)
      next_st.ver_alarm = 1'b1;
    if (pin_now[`PIN_FEED_ERR] && on_line)
      next_st.feed_alarm = 1'b1;
    next_st.alarm_active = next_st.ver_alarm | next_st.feed_alarm;
    next_st.on_line_lamp = on_line;

    // Register bus: address and data are caught in either order.
    if (awvalid && awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end
    if (st.bvalid && bready)
      next_st.bvalid = 1'b0;
    if (st.aw_full && st.w_full && !st.bvalid) begin
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = `RESP_OKAY;
      if (st.aw_addr == `REG_CONFIG) begin
        cfg = cfg_image(st);
        for (int b = 0; b < 4; b++) begin
          merged[b*8 +: 8] = st.w_strb[b] ? st.w_data[b*8 +: 8]
                                          : cfg[b*8 +: 8];
        end
        next_st.cfg_sync     = merged[`CFG_SYNC];
        next_st.cfg_invert   = merged[`CFG_INVERT];
        next_st.cfg_levels   = merged[`CFG_LEVELS_LO+1:`CFG_LEVELS_LO];
        next_st.cfg_interval = merged[`CFG_INTERVAL_LO+4:`CFG_INTERVAL_LO];
        next_st.cfg_header   = merged[`CFG_HEADER_LO+4:`CFG_HEADER_LO];
      end else if (st.aw_addr != `REG_STATUS) begin
        next_st.bresp = `RESP_SLVERR;
      end
    end

    if (st.rvalid && rready)
      next_st.rvalid = 1'b0;
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = `RESP_OKAY;
      if (araddr == `REG_CONFIG) begin
        next_st.rdata = cfg_image(st);
      end else if (araddr == `REG_STATUS) begin
        next_st.rdata = status_image(st, conv_count, on_line);
      end else begin
        next_st.rdata = 32'h0000_0000;
        next_st.rresp = `RESP_SLVERR;
      end
    end
  end

  // Configuration fields reset from one packed word, so the reset image and
  // the readback layout cannot drift apart.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.cfg_sync     <= 1'(`CONFIG_RESET >> `CFG_SYNC);
      st.cfg_invert   <= 1'(`CONFIG_RESET >> `CFG_INVERT);
      st.cfg_levels   <= 2'(`CONFIG_RESET >> `CFG_LEVELS_LO);
      st.cfg_interval <= 5'(`CONFIG_RESET >> `CFG_INTERVAL_LO);
      st.cfg_header   <= 5'(`CONFIG_RESET >> `CFG_HEADER_LO);
    end else begin
      st <= next_st;
    end
  end

  // Converter wiring.
  assign cv.bit_fall   = bit_fall;
  assign cv.char_data  = char_data;
  assign cv.sync_mode  = st.cfg_sync;
  assign cv.invert     = st.cfg_invert;
  assign cv.levels     = st.cfg_levels;
  assign cv.interval   = st.cfg_interval;
  assign cv.header_n   = st.cfg_header;
  assign cv.header_seq = message_header_sequence;
  assign conv_count    = cv.count;

  tape_serializer #(
    .LEVELS (8)
  ) u_serializer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cv      (cv.conv)
  );

  // Bus handshakes.
  assign awready = ~st.aw_full & ~st.bvalid;
  assign wready  = ~st.w_full & ~st.bvalid;
  assign bvalid  = st.bvalid;
  assign bresp   = st.bresp;
  assign arready = ~st.rvalid;
  assign rvalid  = st.rvalid;
  assign rdata   = st.rdata;
  assign rresp   = st.rresp;

  // Block outputs, all from flip-flops.
  assign delete_mode     = st.delete_latch;
  assign reader_stop     = st.reader_stop;
  assign header_step     = st.header_step;
  assign reader_step     = st.reader_step;
  assign step_read_pulse = st.step_read_pulse;
  assign restart_guard   = st.restart_guard;
  assign alarm_active    = st.alarm_active;
  assign verifier_lamp   = st.ver_alarm;
  assign feed_lamp       = st.feed_alarm;
  assign on_line_lamp    = st.on_line_lamp;
  assign serial_out      = cv.serial_out;
  assign char_step       = cv.char_step;
  assign par_out         = cv.par_out;

endmodule

// *** tape_reader_control_serializer_chk.sv ***
`timescale 1ns/100ps
module tape_reader_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched ports
  input wire logic on_line,
  input wire logic seq_step,
  input wire logic delete_mode,
  input wire logic reader_stop,
  input wire logic header_step,
  input wire logic step_read_pulse,
  input wire logic restart_guard,
  input wire logic alarm_active,
  input wire logic verifier_lamp,
  input wire logic feed_lamp,
  input wire logic on_line_lamp,
  input wire logic char_step
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_LAMP: assert property ($rose(on_line) |-> ##[1:2] on_line_lamp)
    else $error("on-line lamp late");
  AST_SUM: assert property ($rose(verifier_lamp) |-> ##[0:1] alarm_active)
    else $error("combined alarm missing");
  AST_FEED: assert property ($rose(feed_lamp) |-> $past(on_line) || $past(on_line, 2))
    else $error("feed alarm set off-line");
  AST_STOP_ON: assert property (reader_stop |-> $past(on_line))
    else $error("stop without on-line");
  AST_STOP_BLK: assert property (reader_stop && $past(reader_stop) |-> !header_step)
    else $error("step passed during stop");
  AST_HDR: assert property (header_step |-> $past(seq_step) && $past(delete_mode))
    else $error("header step without cause");
  AST_CHAR: assert property (char_step |=> !char_step)
    else $error("character step too long");
  AST_SR: assert property (step_read_pulse |-> reader_stop)
    else $error("step read outside stop");
  AST_SR_ONE: assert property (step_read_pulse |=> !step_read_pulse [*3])
    else $error("step read repeated");
  C_CHAR: cover property (char_step);
  C_SR: cover property (step_read_pulse);
  C_GUARD: cover property (restart_guard);
endmodule

bind tape_reader_control_serializer tape_reader_chk tape_reader_chk_inst (.*);

// *** tape_partner.sv ***
`timescale 1ns/100ps
module tape_partner (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Bench control and converter feedback
  input  wire logic step_en,
  input  wire logic char_step,
  // Far side signals
  output logic       bit_clk,
  output logic       seq_step,
  output logic [7:0] char_data
);
  logic [4:0] div;
  // Eight cycles per half bit keeps each level well past the pin filter.
  always @(posedge aclk) begin
    if (!aresetn) begin
      div <= 5'h00;
      bit_clk <= 1'b0;
      seq_step <= 1'b0;
      char_data <= 8'h00;
    end else begin
      div <= div + 5'h01;
      bit_clk <= div[3];
      seq_step <= step_en && (div == 5'h1f);
      if (char_step) char_data <= char_data + 8'h35;
    end
  end
endmodule

// *** tb_tape_reader_control_serializer.sv ***
`timescale 1ns/100ps
`include "tape_reader_defines.svh"
module tb_tape_reader_control_serializer;
  typedef struct {logic ol, ve, fe; logic [2:0] ex;} row_t;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, on_line = 0, header_complete = 0;
  logic        header_delete_set = 0, message_header_sequence = 0;
  logic        step_en = 0, verifier_err = 0, feed_err = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic [2:0]  awprot = 0, arprot = 0;
  logic [4:0]  sw_make = 5'h00, sw_break = 5'h1f;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, seq_step, bit_clk;
  logic        delete_mode, reader_stop, header_step, reader_step, char_step;
  logic        step_read_pulse, restart_guard, alarm_active, serial_out;
  logic        verifier_lamp, feed_lamp, on_line_lamp, sy = 0;
  logic [7:0]  char_data, par_out, iv = 0, lm = 0;
  logic [10:0] frm, ef;
  int          errors = 0, compares = 0, n_hdr = 0, n_rd = 0, n_sr = 0;
  int          n_g = 0, k = 99, nb = 11;
  row_t        rows [4] = '{'{1, 1, 0, 3'b101}, '{1, 0, 1, 3'b011},
                            '{0, 1, 1, 3'b000}, '{1, 1, 1, 3'b111}};
  always #5 aclk = ~aclk;
  tape_reader_control_serializer tape_reader_control_serializer_inst (.*);
  tape_partner tape_partner_inst (.*);
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic sw(input int i, input logic v);
    sw_make[i] <= v;
    sw_break[i] <= !v;
    cyc(12);
  endtask
  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    cyc(1);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    r = bresp;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    cyc(1);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    {d, r} = {rdata, rresp};
  endtask
  // Each frame is sampled at bit clock rises, four cycles after the update.
  always @(posedge bit_clk) if (k < 11) begin
    frm[k] = serial_out;
    k++;
  end
  always @(posedge aclk) begin
    {n_hdr, n_rd} = {n_hdr + header_step, n_rd + reader_step};
    {n_sr, n_g} = {n_sr + step_read_pulse, n_g + restart_guard};
    if (!aresetn) k = 99;
    else if (char_step) begin
      if (k != 99) chk("bits", k, nb);
      if (k == nb)
        chk("frame", frm << (32 - k), ef << (32 - k));
      chk("parallel", par_out, char_data);
      ef = sy ? {3'b111, char_data ^ iv | lm}
              : {2'b11, char_data ^ iv | lm, 1'b0};
      k = 0;
    end
  end
  initial begin
    cyc(20000);
    errors++;
    end_sim();
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          h, m, g;
    cyc(16);
    aresetn <= 1;
    cyc(2);
    rd(`REG_CONFIG, d, r);
    chk("config", d, `CONFIG_RESET);
    rd(32'h8, d, r);
    chk("unmapped", {d[29:0], r}, `RESP_SLVERR);
    wr(`REG_STATUS, 32'hffff_ffff, r);
    chk("status write", r, `RESP_OKAY);
    foreach (rows[i]) begin
      {on_line, verifier_err, feed_err} <= {rows[i].ol, rows[i].ve, rows[i].fe};
      cyc(10);
      chk("alarms", {verifier_lamp, feed_lamp, alarm_active}, rows[i].ex);
      chk("lamp", on_line_lamp, rows[i].ol);
      {verifier_err, feed_err} <= 2'b00;
      sw(`SW_VER_RESET, 1);
      sw(`SW_FEED_RESET, 1);
      sw(`SW_VER_RESET, 0);
      sw(`SW_FEED_RESET, 0);
      chk("cleared", {verifier_lamp, feed_lamp, alarm_active}, 0);
    end
    {step_en, header_delete_set} <= 2'b11;
    cyc(1);
    header_delete_set <= 0;
    h = n_hdr;
    cyc(100);
    chk("header steps", {delete_mode, n_hdr > h}, 2'b11);
    {header_complete, on_line} <= 2'b10;
    cyc(3);
    header_complete <= 0;
    cyc(3);
    on_line <= 1;
    cyc(3);
    chk("delete kept", delete_mode, 1);
    header_complete <= 1;
    cyc(3);
    header_complete <= 0;
    cyc(3);
    chk("delete cleared", delete_mode, 0);
    {h, m} = {n_hdr, n_rd};
    cyc(100);
    chk("routed", {n_hdr == h, n_rd > m}, 2'b11);
    sw(`SW_STOP, 1);
    chk("stop", reader_stop, 1);
    {m, g} = {n_rd, n_sr};
    sw(`SW_STEP_READ, 1);
    sw(`SW_STEP_READ, 0);
    sw(`SW_STEP, 1);
    sw(`SW_STEP, 0);
    chk("step read", n_sr - g, 1);
    chk("stop steps", n_rd - m, 2);
    g = n_g;
    sw(`SW_STOP, 0);
    chk("guard", n_g - g, 1);
    step_en <= 0;
    cyc(3);
    m = n_rd;
    sw(`SW_STEP, 1);
    sw(`SW_STEP, 0);
    chk("held", n_rd - m, 0);
    on_line <= 0;
    sw(`SW_STEP, 1);
    sw(`SW_STEP, 0);
    chk("off-line step", n_rd - m, 1);
    aresetn <= 0;
    cyc(4);
    aresetn <= 1;
    cyc(2);
    chk("reset", {reader_stop, delete_mode, alarm_active, serial_out}, 1);
    cyc(500);
    // Synchronous, inverted, six levels; frames spanning a change are skipped.
    k = 99;
    {sy, iv, lm} = {1'b1, 8'hff, 8'hc0};
    nb = 9;
    wr(`REG_CONFIG, 32'h000a_0907, r);
    chk("config write", r, `RESP_OKAY);
    cyc(1);
    k = 99;
    rd(`REG_CONFIG, d, r);
    chk("config read", d, 32'h000a_0907);
    cyc(600);
    k = 99;
    nb = 10;
    message_header_sequence <= 1;
    cyc(1);
    k = 99;
    cyc(600);
    end_sim();
  end
endmodule
